// *** rtl/dcc_pkg.sv ***
package dcc_pkg;
	localparam logic [3:0] DCC_OFF_CTRL1 = 4'h0;
	localparam logic [3:0] DCC_OFF_CTRL2 = 4'h4;
	localparam logic [3:0] DCC_OFF_AUX = 4'h8;
	localparam logic [3:0] DCC_OFF_IRQ = 4'hC;
	localparam int DCC_BIT_EN = 7;
	localparam int DCC_BIT_RES = 6;
	localparam int DCC_BIT_DRV = 5;
	localparam int DCC_BIT_INV = 4;
	localparam int DCC_BIT_REF = 2;
	localparam int DCC_BIT_MIR1 = 7;
	localparam int DCC_BIT_MIR2 = 6;
	localparam int DCC_AUX_SYNC = 0;
	localparam int DCC_AUX_GSRC = 1;
	localparam int DCC_IRQ_FLAG0 = 0;
	localparam int DCC_IRQ_EN0 = 2;
	localparam int DCC_IRQ_PERIPHERAL_IRQ_ENABLE = 4;
	localparam int DCC_IRQ_GIE = 5;
	localparam logic [7:0] DCC_CTRL_RESET = 8'h00;
	localparam logic [1:0] DCC_AUX_RESET = 2'h2;
	localparam logic [7:0] DCC_CTRL_WMASK = 8'hB7;
	localparam logic [1:0] DCC_PHASES = 2'h3;
	localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
	localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;
	// per-comparator control fields
	typedef struct packed {
		logic en;
		logic drv;
		logic inv;
		logic ref_sel;
		logic [1:0] chan;
	} dcc_ctrl_s;
	// per-comparator analog steering towards the core
	typedef struct packed {
		logic power_on;
		logic ref_sel;
		logic [1:0] chan;
	} dcc_analog_s;
endpackage

// *** rtl/dcc_top.sv ***
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module dcc_top
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// axi4-lite write address, data and response
	input wire logic [3:0] s_awaddr_in,
	input wire logic s_awvalid_in,
	output logic s_awready_out,
	input wire logic [31:0] s_wdata_in,
	input wire logic [3:0] s_wstrb_in,
	input wire logic s_wvalid_in,
	output logic s_wready_out,
	output logic [1:0] s_bresp_out,
	output logic s_bvalid_out,
	input wire logic s_bready_in,
	// axi4-lite read
	input wire logic [3:0] s_araddr_in,
	input wire logic s_arvalid_in,
	output logic s_arready_out,
	output logic [31:0] s_rdata_out,
	output logic [1:0] s_rresp_out,
	output logic s_rvalid_out,
	input wire logic s_rready_in,
	// analog cores and pins
	input wire logic [1:0] cmp_raw_in,
	input wire logic [1:0] pin_direction_in,
	output dcc_pkg::dcc_analog_s [1:0] cmp_analog_out,
	output logic [1:0] cmp_pin_out,
	output logic [1:0] cmp_pin_oe_out,
	output logic [1:0] port_override_out,
	// interrupt, wake and aux config
	output logic [1:0] cmp_irq_flag_out,
	output logic irq_req_out,
	output logic wake_out,
	output logic [1:0] aux_cfg_out
);
	import dcc_pkg::*;

	typedef struct packed {
		logic aw_got;
		logic [3:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		dcc_ctrl_s [1:0] ctrl;
		logic [1:0] aux;
		logic [1:0] ie;
		logic peripheral_irq_enable;
		logic global_irq_enable;
		logic [1:0] phase;
		logic [1:0] result;
		logic [1:0] latch_read;
		logic [1:0] latch_q1;
		logic [1:0] mis_prev;
		logic [1:0] flag;
		logic irq;
		logic wake;
		dcc_analog_s [1:0] analog;
		logic [1:0] pin;
		logic [1:0] pin_oe;
		logic [1:0] ovr;
	} dcc_state_s;

	dcc_state_s st_reg;
	dcc_state_s st_next;
	logic [1:0] res_now;
	logic [1:0] mismatch;
	logic [1:0] ctrl_rd;
	logic [1:0] ctrl_wr;
	logic [1:0] flag_wr0;
	logic [1:0] flag_wr1;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] ctrl_byte [1:0];

	// polarity-adjusted result per comparator, forced low while disabled
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cmp
			assign res_now[gi] = st_reg.ctrl[gi].en & (cmp_raw_in[gi] ^ st_reg.ctrl[gi].inv);
			assign mismatch[gi] = st_reg.latch_read[gi] ^ st_reg.latch_q1[gi];
			assign ctrl_byte[gi] = {st_reg.ctrl[gi].en, st_reg.result[gi], st_reg.ctrl[gi].drv,
				st_reg.ctrl[gi].inv, 1'b0, st_reg.ctrl[gi].ref_sel, st_reg.ctrl[gi].chan};
		end
	endgenerate

	// bus strobes
	always_comb
	begin
		wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
		rd_fire = s_arvalid_in && !st_reg.rvalid;
		ctrl_rd[0] = rd_fire && (s_araddr_in == DCC_OFF_CTRL1);
		ctrl_rd[1] = rd_fire && (s_araddr_in == DCC_OFF_CTRL2);
		ctrl_wr[0] = wr_fire && (st_reg.aw_addr == DCC_OFF_CTRL1) && st_reg.w_strb[0];
		ctrl_wr[1] = wr_fire && (st_reg.aw_addr == DCC_OFF_CTRL2) && st_reg.w_strb[0];
		for (int i = 0; i < 2; i++)
		begin
			flag_wr0[i] = wr_fire && (st_reg.aw_addr == DCC_OFF_IRQ) && st_reg.w_strb[0]
				&& !st_reg.w_data[DCC_IRQ_FLAG0 + i];
			flag_wr1[i] = wr_fire && (st_reg.aw_addr == DCC_OFF_IRQ) && st_reg.w_strb[0]
				&& st_reg.w_data[DCC_IRQ_FLAG0 + i];
		end
	end

	// next state
	always_comb
	begin
		st_next = st_reg;
		// write channel capture
		if (s_awvalid_in && !st_reg.aw_got)
		begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = s_awaddr_in;
		end
		if (s_wvalid_in && !st_reg.w_got)
		begin
			st_next.w_got = 1'b1;
			st_next.w_data = s_wdata_in;
			st_next.w_strb = s_wstrb_in;
		end
		if (wr_fire)
		begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = DCC_RESP_OKAY;
			if (st_reg.aw_addr == DCC_OFF_CTRL1 || st_reg.aw_addr == DCC_OFF_CTRL2)
			begin
				if (st_reg.w_strb[0])
				begin
					// result bit and bit 3 are not writable
					for (int i = 0; i < 2; i++)
						if (ctrl_wr[i])
						begin
							st_next.ctrl[i].en = st_reg.w_data[DCC_BIT_EN];
							st_next.ctrl[i].drv = st_reg.w_data[DCC_BIT_DRV];
							st_next.ctrl[i].inv = st_reg.w_data[DCC_BIT_INV];
							st_next.ctrl[i].ref_sel = st_reg.w_data[DCC_BIT_REF];
							st_next.ctrl[i].chan = st_reg.w_data[1:0];
						end
				end
			end
			else if (st_reg.aw_addr == DCC_OFF_AUX)
			begin
				if (st_reg.w_strb[0])
					st_next.aux = st_reg.w_data[1:0];
			end
			else if (st_reg.aw_addr == DCC_OFF_IRQ)
			begin
				if (st_reg.w_strb[0])
				begin
					st_next.ie = st_reg.w_data[DCC_IRQ_EN0 +: 2];
					st_next.peripheral_irq_enable = st_reg.w_data[DCC_IRQ_PERIPHERAL_IRQ_ENABLE];
					st_next.global_irq_enable = st_reg.w_data[DCC_IRQ_GIE];
				end
			end
			else
				st_next.bresp = DCC_RESP_SLVERR;
		end
		if (st_reg.bvalid && s_bready_in)
			st_next.bvalid = 1'b0;
		// read channel
		if (rd_fire)
		begin
			st_next.rvalid = 1'b1;
			st_next.rresp = DCC_RESP_OKAY;
			st_next.rdata = 32'h0;
			if (s_araddr_in == DCC_OFF_CTRL1)
				st_next.rdata[7:0] = ctrl_byte[0];
			else if (s_araddr_in == DCC_OFF_CTRL2)
				st_next.rdata[7:0] = ctrl_byte[1];
			else if (s_araddr_in == DCC_OFF_AUX)
				st_next.rdata[7:0] = {st_reg.result[0], st_reg.result[1], 4'h0, st_reg.aux};
			else if (s_araddr_in == DCC_OFF_IRQ)
				st_next.rdata[7:0] = {2'h0, st_reg.global_irq_enable, st_reg.peripheral_irq_enable, st_reg.ie, st_reg.flag};
			else
				st_next.rresp = DCC_RESP_SLVERR;
		end
		if (st_reg.rvalid && s_rready_in)
			st_next.rvalid = 1'b0;
		// instruction cycle phase divider, phase 0 is the first clock phase
		st_next.phase = (st_reg.phase == DCC_PHASES) ? 2'h0 : st_reg.phase + 2'h1;
		for (int i = 0; i < 2; i++)
		begin
			if (st_reg.phase == 2'h0)
			begin
				st_next.result[i] = res_now[i];
				st_next.latch_q1[i] = res_now[i];
			end
			if (ctrl_rd[i] || ctrl_wr[i])
				st_next.latch_read[i] = st_reg.latch_q1[i];
			st_next.mis_prev[i] = mismatch[i];
			// set beats clear; flag independent of pin drive
			if (flag_wr0[i])
				st_next.flag[i] = 1'b0;
			if (flag_wr1[i] || (mismatch[i] && !st_reg.mis_prev[i]))
				st_next.flag[i] = 1'b1;
			st_next.analog[i].power_on = st_reg.ctrl[i].en;
			st_next.analog[i].ref_sel = st_reg.ctrl[i].ref_sel;
			st_next.analog[i].chan = st_reg.ctrl[i].chan;
			st_next.pin[i] = res_now[i];
			st_next.pin_oe[i] = st_reg.ctrl[i].drv && st_reg.ctrl[i].en
				&& !pin_direction_in[i];
			st_next.ovr[i] = st_reg.ctrl[i].drv;
		end
		st_next.irq = st_reg.global_irq_enable && st_reg.peripheral_irq_enable && |(st_reg.flag & st_reg.ie);
		st_next.wake = st_reg.peripheral_irq_enable && |(st_reg.flag & st_reg.ie);
	end

	// state register
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_reg <= '0;
			st_reg.aux <= DCC_AUX_RESET;
			st_reg.ctrl[0] <= dcc_ctrl_s'({DCC_CTRL_RESET[7], DCC_CTRL_RESET[5:4],
				DCC_CTRL_RESET[2:0]});
			st_reg.ctrl[1] <= dcc_ctrl_s'({DCC_CTRL_RESET[7], DCC_CTRL_RESET[5:4],
				DCC_CTRL_RESET[2:0]});
		end
		else
			st_reg <= st_next;
	end

	// outputs straight from the state register
	assign s_awready_out = !st_reg.aw_got;
	assign s_wready_out = !st_reg.w_got;
	assign s_bvalid_out = st_reg.bvalid;
	assign s_bresp_out = st_reg.bresp;
	assign s_arready_out = !st_reg.rvalid;
	assign s_rvalid_out = st_reg.rvalid;
	assign s_rdata_out = st_reg.rdata;
	assign s_rresp_out = st_reg.rresp;
	assign cmp_analog_out = st_reg.analog;
	assign cmp_pin_out = st_reg.pin;
	assign cmp_pin_oe_out = st_reg.pin_oe;
	assign port_override_out = st_reg.ovr;
	assign cmp_irq_flag_out = st_reg.flag;
	assign irq_req_out = st_reg.irq;
	assign wake_out = st_reg.wake;
	assign aux_cfg_out = st_reg.aux;

	// checks
	property p_flag_edge;
		@(posedge clk_in) disable iff (rst_in)
		(mismatch[0] && !st_reg.mis_prev[0]) |=> st_reg.flag[0];
	endproperty
	a_flag_edge: assert property (p_flag_edge) else $error("flag missed mismatch edge");

	property p_flag_clear;
		@(posedge clk_in) disable iff (rst_in)
		(flag_wr0[1] && !(mismatch[1] && !st_reg.mis_prev[1])) |=> !st_reg.flag[1];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_irq;
		@(posedge clk_in) disable iff (rst_in)
		##1 irq_req_out == $past(st_reg.global_irq_enable && st_reg.peripheral_irq_enable && |(st_reg.flag & st_reg.ie));
	endproperty
	a_irq: assert property (p_irq) else $error("irq gating wrong");

	property p_read_clears;
		@(posedge clk_in) disable iff (rst_in)
		ctrl_rd[0] |=> st_reg.latch_read[0] == $past(st_reg.latch_q1[0]);
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not refresh latch");

	property p_write_clears;
		@(posedge clk_in) disable iff (rst_in)
		ctrl_wr[1] |=> st_reg.latch_read[1] == $past(st_reg.latch_q1[1]);
	endproperty
	a_write_clears: assert property (p_write_clears) else $error("write did not refresh latch");

	property p_pin_oe;
		@(posedge clk_in) disable iff (rst_in)
		##1 cmp_pin_oe_out[0] == $past(st_reg.ctrl[0].drv && st_reg.ctrl[0].en
			&& !pin_direction_in[0]);
	endproperty
	a_pin_oe: assert property (p_pin_oe) else $error("pin drive gating wrong");

	property p_off_low;
		@(posedge clk_in) disable iff (rst_in)
		(!st_reg.ctrl[0].en && st_reg.phase == 2'h0) |=> !st_reg.latch_q1[0];
	endproperty
	a_off_low: assert property (p_off_low) else $error("disabled comparator active");

	property p_sample;
		@(posedge clk_in) disable iff (rst_in)
		(st_reg.phase == 2'h0) |=> st_reg.result[1] == $past(res_now[1]);
	endproperty
	a_sample: assert property (p_sample) else $error("result not sampled");

	property p_wake;
		@(posedge clk_in) disable iff (rst_in)
		(st_reg.peripheral_irq_enable && (st_reg.flag[0] && st_reg.ie[0])) |=> wake_out;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");

	// aux mirror reads must leave the read latches alone
	property p_aux_keeps;
		@(posedge clk_in) disable iff (rst_in)
		(rd_fire && s_araddr_in == DCC_OFF_AUX && !ctrl_wr[0] && !ctrl_wr[1])
			|=> $stable(st_reg.latch_read);
	endproperty
	a_aux_keeps: assert property (p_aux_keeps) else $error("aux read moved latch");

	// result bit only moves on the phase-0 sample, never by a write
	property p_res_ro;
		@(posedge clk_in) disable iff (rst_in)
		(st_reg.phase != 2'h0) |=> $stable(st_reg.result);
	endproperty
	a_res_ro: assert property (p_res_ro) else $error("result bit moved off phase");

	// pin follows the adjusted result one clock later
	property p_pin_pass;
		@(posedge clk_in) disable iff (rst_in)
		##1 cmp_pin_out == $past(res_now);
	endproperty
	a_pin_pass: assert property (p_pin_pass) else $error("pin path wrong");

	// no edge and no software set keeps a clear flag clear
	property p_no_edge;
		@(posedge clk_in) disable iff (rst_in)
		(!flag_wr1[0] && !(mismatch[0] && !st_reg.mis_prev[0]) && !st_reg.flag[0])
			|=> !st_reg.flag[0];
	endproperty
	a_no_edge: assert property (p_no_edge) else $error("flag set without edge");

	// software may set the flag itself
	property p_flag_set;
		@(posedge clk_in) disable iff (rst_in)
		flag_wr1[1] |=> st_reg.flag[1];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag write one lost");

	// second comparator has its own edge detector
	property p_own_flag;
		@(posedge clk_in) disable iff (rst_in)
		(mismatch[1] && !st_reg.mis_prev[1]) |=> st_reg.flag[1];
	endproperty
	a_own_flag: assert property (p_own_flag) else $error("second flag missed edge");

	// no wake without the peripheral enable
	property p_wake_off;
		@(posedge clk_in) disable iff (rst_in)
		!st_reg.peripheral_irq_enable |=> !wake_out;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("wake without enable");

	// override follows the drive bit alone
	property p_ovr;
		@(posedge clk_in) disable iff (rst_in)
		##1 port_override_out[1] == $past(st_reg.ctrl[1].drv);
	endproperty
	a_ovr: assert property (p_ovr) else $error("override gating wrong");

	// reference steering towards the core
	property p_ref_route;
		@(posedge clk_in) disable iff (rst_in)
		##1 cmp_analog_out[1].ref_sel == $past(st_reg.ctrl[1].ref_sel);
	endproperty
	a_ref_route: assert property (p_ref_route) else $error("reference steering wrong");

	// channel steering towards the core
	property p_chan_route;
		@(posedge clk_in) disable iff (rst_in)
		##1 cmp_analog_out[0].chan == $past(st_reg.ctrl[0].chan);
	endproperty
	a_chan_route: assert property (p_chan_route) else $error("channel steering wrong");

	c_mismatch: cover property (@(posedge clk_in) disable iff (rst_in) mismatch[0]);
	c_wake: cover property (@(posedge clk_in) disable iff (rst_in) wake_out);
	c_irq: cover property (@(posedge clk_in) disable iff (rst_in) irq_req_out);
	c_wr: cover property (@(posedge clk_in) disable iff (rst_in) ctrl_wr[0]);
endmodule

// *** verif/dcc_analog_model.sv ***
`timescale 1ns/10ps
module dcc_analog_model
import dcc_pkg::*;
(
	// clock
	input wire logic clk_in,
	// analog levels chosen by the bench
	input wire logic [3:0][7:0] neg_lvl_in,
	input wire logic [1:0][7:0] pos_lvl_in,
	input wire logic [7:0] vref_lvl_in,
	// steering from the block, result back to it
	input dcc_pkg::dcc_analog_s [1:0] analog_in,
	output logic [1:0] cmp_raw_out
);
	// start low so the block never sees an unknown result
	initial cmp_raw_out = 2'h0;
	// each core compares its routed inputs; an unpowered core reads low
	always @(posedge clk_in)
	begin
		for (int i = 0; i < 2; i++)
			cmp_raw_out[i] <= analog_in[i].power_on &&
				((analog_in[i].ref_sel ? vref_lvl_in : pos_lvl_in[i]) >
				neg_lvl_in[analog_in[i].chan]);
	end
endmodule

// *** verif/dual_comparator_control_test.sv ***
`timescale 1ns/10ps
module dual_comparator_control_test;
	import dcc_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, wake, res;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp, raw, pin, oe, ovr, flag, aux, pin_dir = 2'h0;
	dcc_analog_s [1:0] ana;
	logic [3:0][7:0] neg_lvl = '0;
	logic [1:0][7:0] pos_lvl = '0;
	logic [7:0] vref = 8'h0, cfg, vp;
	logic [33:0] exp_q [$];
	int n_errors = 0, samples_checked = 0;
	integer seed = 32'he59a39f5;
	dcc_top uut (.clk_in(clk_in), .rst_in(rst_in), .s_awaddr_in(awaddr), .s_awvalid_in(awvalid),
		.s_awready_out(awready), .s_wdata_in(wdata), .s_wstrb_in(wstrb), .s_wvalid_in(wvalid),
		.s_wready_out(wready), .s_bresp_out(bresp), .s_bvalid_out(bvalid), .s_bready_in(bready),
		.s_araddr_in(araddr), .s_arvalid_in(arvalid), .s_arready_out(arready),
		.s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rvalid), .s_rready_in(rready),
		.cmp_raw_in(raw), .pin_direction_in(pin_dir), .cmp_analog_out(ana), .cmp_pin_out(pin),
		.cmp_pin_oe_out(oe), .port_override_out(ovr), .cmp_irq_flag_out(flag),
		.irq_req_out(irq), .wake_out(wake), .aux_cfg_out(aux));
	dcc_analog_model model (.clk_in(clk_in), .neg_lvl_in(neg_lvl), .pos_lvl_in(pos_lvl),
		.vref_lvl_in(vref), .analog_in(ana), .cmp_raw_out(raw));
	// 25 MHz clock
	initial forever #20 clk_in = ~clk_in;
	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_val(input logic [33:0] got, input logic [33:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one clock edge of a bounded wait
	task automatic tick(inout int wt);
		@(posedge clk_in);
		wt++;
		if (wt > 100)
		begin
			n_errors++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		int wt;
		bit aw_ok, w_ok, hit_aw, hit_w, done;
		wt = 0;
		aw_ok = 0;
		w_ok = 0;
		done = 0;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= {24'($random(seed)), d};
		wstrb <= {3'($random(seed)), 1'b1};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		exp_q.push_back({DCC_RESP_OKAY, 32'h0});
		do
		begin
			// handshakes as they stand for the coming edge
			@(negedge clk_in);
			hit_aw = awvalid && awready;
			hit_w = wvalid && wready;
			tick(wt);
			aw_ok |= hit_aw;
			w_ok |= hit_w;
			if (hit_aw)
				awvalid <= 1'b0;
			if (hit_w)
				wvalid <= 1'b0;
		end while (!(aw_ok && w_ok));
		do
		begin
			@(negedge clk_in);
			done = bvalid;
			tick(wt);
		end while (!done);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		int wt;
		bit hit;
		wt = 0;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		exp_q.push_back(e);
		do
		begin
			@(negedge clk_in);
			hit = arready;
			tick(wt);
		end while (!hit);
		arvalid <= 1'b0;
		do
		begin
			@(negedge clk_in);
			hit = rvalid;
			tick(wt);
		end while (!hit);
		rready <= 1'b0;
	endtask
	// result watcher: every response is matched against the oldest note
	always @(negedge clk_in)
		if ((bvalid && bready) || (rvalid && rready))
			chk_val(bvalid ? {bresp, 32'h0} : {rresp, rdata}, exp_q.pop_front());
	// main sequence
	initial
	begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(DCC_OFF_CTRL1, 34'h0);
		rd(DCC_OFF_CTRL2, 34'h0);
		rd(DCC_OFF_AUX, 34'h2);
		rd(4'h2, {DCC_RESP_SLVERR, 32'h0});
		$display("reset test done");
		for (int i = 0; i < 2; i++)
		begin
			for (int c = 0; c < 16; c++)
			begin
				neg_lvl <= 32'($random(seed));
				pos_lvl <= 16'($random(seed));
				vref <= 8'($random(seed));
				cfg = {3'h4, c[3], 1'b0, c[2], c[1:0]};
				wr(i ? DCC_OFF_CTRL2 : DCC_OFF_CTRL1, cfg | (8'($random(seed)) & 8'h48));
				repeat (12) @(posedge clk_in);
				vp = c[2] ? vref : pos_lvl[i];
				res = (vp > neg_lvl[c[1:0]]) ^ c[3];
				rd(i ? DCC_OFF_CTRL2 : DCC_OFF_CTRL1, {27'h0, res, cfg[5:0]} | 34'h80);
				rd(DCC_OFF_AUX, {26'h0, i == 0 && res, i == 1 && res, 6'h02});
				chk_val(34'(ana[i]), {30'h0, 1'b1, c[2], 2'(c)});
			end
			wr(i ? DCC_OFF_CTRL2 : DCC_OFF_CTRL1, 8'h00);
			repeat (3) @(posedge clk_in);
			chk_val(34'(ana[i]), 34'h0);
		end
		$display("config sweep done");
		wr(DCC_OFF_CTRL1, 8'hA0);
		wr(DCC_OFF_CTRL2, 8'h20);
		for (int d = 0; d < 4; d++)
		begin
			pin_dir <= 2'(d);
			repeat (3) @(posedge clk_in);
			chk_val(34'(oe), {33'h0, ~d[0]});
			chk_val(34'(ovr), 34'h3);
		end
		$display("pin test done");
		pos_lvl <= 16'h00C8;
		neg_lvl <= 32'h64;
		wr(DCC_OFF_CTRL1, 8'h80);
		repeat (12) @(posedge clk_in);
		rd(DCC_OFF_CTRL1, 34'hC0);
		chk_val(34'(pin), 34'h1);
		wr(DCC_OFF_IRQ, 8'h00);
		repeat (12) @(posedge clk_in);
		rd(DCC_OFF_IRQ, 34'h0);
		neg_lvl <= 32'hFA;
		repeat (12) @(posedge clk_in);
		rd(DCC_OFF_AUX, 34'h02);
		rd(DCC_OFF_IRQ, 34'h1);
		wr(DCC_OFF_IRQ, 8'h00);
		repeat (12) @(posedge clk_in);
		rd(DCC_OFF_IRQ, 34'h0);
		neg_lvl <= 32'h64;
		repeat (12) @(posedge clk_in);
		rd(DCC_OFF_IRQ, 34'h0);
		neg_lvl <= 32'hFA;
		repeat (12) @(posedge clk_in);
		rd(DCC_OFF_IRQ, 34'h1);
		wr(DCC_OFF_CTRL1, 8'h80);
		wr(DCC_OFF_IRQ, 8'h00);
		neg_lvl <= 32'h64;
		repeat (12) @(posedge clk_in);
		rd(DCC_OFF_IRQ, 34'h1);
		wr(DCC_OFF_IRQ, 8'h35);
		repeat (2) @(posedge clk_in);
		chk_val({30'h0, irq, wake, flag}, 34'hD);
		wr(DCC_OFF_IRQ, 8'h15);
		repeat (2) @(posedge clk_in);
		chk_val({30'h0, irq, wake, flag}, 34'h5);
		wr(DCC_OFF_IRQ, 8'h3A);
		repeat (2) @(posedge clk_in);
		chk_val({30'h0, irq, wake, flag}, 34'hE);
		rd(DCC_OFF_IRQ, 34'h3A);
		$display("interrupt test done");
		wrap_up();
	end
endmodule
